// file: core/rlcs_pkg.sv
// shared constants and types for the lane configuration select block
package rlcs_pkg;
   localparam int NUM_LANES = 4;
   localparam int NUM_SIDES = 2;

   // three-level pin state
   typedef enum logic [1:0] {
      RLCS_LVL_LOW   = 2'h0,
      RLCS_LVL_HIGH  = 2'h1,
      RLCS_LVL_FLOAT = 2'h2
   } rlcs_lvl_t;

   // equalization index, 0 = bypass, rising boost
   localparam logic [3:0] EQ_BYPASS = 4'h0;
   localparam logic [3:0] EQ_4P0    = 4'h1;
   localparam logic [3:0] EQ_9P6    = 4'h2;
   localparam logic [3:0] EQ_11P4   = 4'h3;
   localparam logic [3:0] EQ_15P5   = 4'h4;
   localparam logic [3:0] EQ_17P0   = 4'h5;
   localparam logic [3:0] EQ_19P1   = 4'h6;
   localparam logic [3:0] EQ_20P6   = 4'h7;
   localparam logic [3:0] EQ_26P3   = 4'h8;

   // de-emphasis level codes
   localparam logic [2:0] DE_0DB    = 3'h0;
   localparam logic [2:0] DE_3P5DB  = 3'h1;
   localparam logic [2:0] DE_6DB    = 3'h2;
   localparam logic [2:0] DE_9DB    = 3'h3;
   localparam logic [2:0] DE_12DB   = 3'h4;

   // pulse width codes
   localparam logic [1:0] PW_NONE   = 2'h0;
   localparam logic [1:0] PW_400PS  = 2'h1;
   localparam logic [1:0] PW_200PS  = 2'h2;

   // output swing codes
   localparam logic [1:0] SW_1000MV = 2'h0;
   localparam logic [1:0] SW_1200MV = 2'h1;
   localparam logic [1:0] SW_1400MV = 2'h2;

   // register defaults: bypass eq, no de-emphasis, terminated, low rate
   localparam logic [3:0] REG_EQ_RST   = 4'h0;
   localparam logic [2:0] REG_DE_RST   = 3'h0;
   localparam logic       REG_ENH_RST  = 1'b0;
   localparam logic [1:0] REG_SW_RST   = 2'h0;
   localparam logic       REG_TDIS_RST = 1'b0;
   localparam logic [1:0] REG_RATE_RST = 2'h0;

   // register bus map, one word per lane plus a global word and a status word
   localparam logic [3:0] ADDR_LANE0  = 4'h0;
   localparam logic [3:0] ADDR_GLOBAL = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'h9;

   // lane word fields
   localparam int F_EQ_LO   = 0;
   localparam int F_DE_LO   = 4;
   localparam int F_ENH     = 7;
   localparam int F_SW_LO   = 8;
   localparam int F_TDIS    = 10;
   localparam int F_TOVR    = 11;

   // global word fields
   localparam int F_RATE_LO = 0;
   localparam int F_POVR    = 2;

   // rate source codes
   localparam logic [1:0] RATE_LOW  = 2'h0;
   localparam logic [1:0] RATE_HIGH = 2'h1;
   localparam logic [1:0] RATE_AUTO = 2'h2;

   typedef enum logic [1:0] {
      RLCS_ST_PIN  = 2'h0,
      RLCS_ST_MGMT = 2'h1,
      RLCS_ST_HOLD = 2'h3
   } rlcs_mode_t;
endpackage

// file: core/rlcs_eq_decode.sv
// three-level equalization pin pair decoder
`timescale 1ns/1ns
module rlcs_eq_decode (
   input  wire logic [1:0] bit1_i,
   input  wire logic [1:0] bit0_i,
   output logic      [3:0] eq_o
);
   always_comb begin
      eq_o = rlcs_pkg::EQ_BYPASS;
      unique case ({bit1_i, bit0_i})
         {rlcs_pkg::RLCS_LVL_FLOAT, rlcs_pkg::RLCS_LVL_FLOAT}:
            eq_o = rlcs_pkg::EQ_BYPASS;
         {rlcs_pkg::RLCS_LVL_HIGH, rlcs_pkg::RLCS_LVL_HIGH}:
            eq_o = rlcs_pkg::EQ_4P0;
         {rlcs_pkg::RLCS_LVL_LOW, rlcs_pkg::RLCS_LVL_LOW}:
            eq_o = rlcs_pkg::EQ_9P6;
         {rlcs_pkg::RLCS_LVL_FLOAT, rlcs_pkg::RLCS_LVL_LOW}:
            eq_o = rlcs_pkg::EQ_11P4;
         {rlcs_pkg::RLCS_LVL_HIGH, rlcs_pkg::RLCS_LVL_LOW}:
            eq_o = rlcs_pkg::EQ_15P5;
         {rlcs_pkg::RLCS_LVL_FLOAT, rlcs_pkg::RLCS_LVL_HIGH}:
            eq_o = rlcs_pkg::EQ_17P0;
         {rlcs_pkg::RLCS_LVL_LOW, rlcs_pkg::RLCS_LVL_HIGH}:
            eq_o = rlcs_pkg::EQ_19P1;
         {rlcs_pkg::RLCS_LVL_LOW, rlcs_pkg::RLCS_LVL_FLOAT}:
            eq_o = rlcs_pkg::EQ_20P6;
         {rlcs_pkg::RLCS_LVL_HIGH, rlcs_pkg::RLCS_LVL_FLOAT}:
            eq_o = rlcs_pkg::EQ_26P3;
         // illegal level code 3 falls back to bypass
         default: eq_o = rlcs_pkg::EQ_BYPASS;
      endcase
   end
endmodule

// file: core/rlcs_de_decode.sv
// three-level de-emphasis pin pair decoder
`timescale 1ns/1ns
module rlcs_de_decode (
   input  wire logic [1:0] bit1_i,
   input  wire logic [1:0] bit0_i,
   input  wire logic       high_rate_i,
   output logic      [2:0] level_o,
   output logic      [1:0] width_o,
   output logic            enh_o,
   output logic      [1:0] swing_o,
   output logic            rsvd_o
);
   logic [1:0] pw;

   // pulse width follows rate; level, enhancement and swing do not
   assign pw = high_rate_i ? rlcs_pkg::PW_200PS : rlcs_pkg::PW_400PS;

   always_comb begin
      level_o = rlcs_pkg::DE_0DB;
      width_o = rlcs_pkg::PW_NONE;
      enh_o   = 1'b0;
      swing_o = rlcs_pkg::SW_1000MV;
      rsvd_o  = 1'b0;
      unique case ({bit1_i, bit0_i})
         {rlcs_pkg::RLCS_LVL_LOW, rlcs_pkg::RLCS_LVL_LOW}: begin
            level_o = rlcs_pkg::DE_0DB;
         end
         {rlcs_pkg::RLCS_LVL_LOW, rlcs_pkg::RLCS_LVL_HIGH}: begin
            level_o = rlcs_pkg::DE_3P5DB;
            width_o = pw;
         end
         {rlcs_pkg::RLCS_LVL_HIGH, rlcs_pkg::RLCS_LVL_LOW}: begin
            level_o = rlcs_pkg::DE_6DB;
            width_o = pw;
         end
         {rlcs_pkg::RLCS_LVL_HIGH, rlcs_pkg::RLCS_LVL_HIGH}: begin
            level_o = rlcs_pkg::DE_6DB;
            width_o = pw;
            enh_o   = 1'b1;
         end
         {rlcs_pkg::RLCS_LVL_LOW, rlcs_pkg::RLCS_LVL_FLOAT}: begin
            level_o = rlcs_pkg::DE_9DB;
            width_o = pw;
            enh_o   = 1'b1;
         end
         {rlcs_pkg::RLCS_LVL_HIGH, rlcs_pkg::RLCS_LVL_FLOAT}: begin
            level_o = rlcs_pkg::DE_12DB;
            width_o = pw;
            enh_o   = 1'b1;
         end
         {rlcs_pkg::RLCS_LVL_FLOAT, rlcs_pkg::RLCS_LVL_LOW}: begin
            level_o = rlcs_pkg::DE_9DB;
            width_o = pw;
            enh_o   = 1'b1;
            swing_o = rlcs_pkg::SW_1200MV;
         end
         {rlcs_pkg::RLCS_LVL_FLOAT, rlcs_pkg::RLCS_LVL_HIGH}: begin
            level_o = rlcs_pkg::DE_12DB;
            width_o = pw;
            enh_o   = 1'b1;
            swing_o = rlcs_pkg::SW_1400MV;
         end
         // float/float and illegal codes are reserved
         default: rsvd_o = 1'b1;
      endcase
   end
endmodule

// file: core/rlcs_top.sv
// lane configuration select: pin decode, registers and per-lane outputs
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
// What this block does
// - mode select low takes eq and de-emphasis from pins per side.
// - active de-emphasis setting raises swing to its decoded value.
// - in pin mode termination input picks 50 ohm or high impedance.
// - in management mode eq, de-emphasis, termination set per lane.
// - mode select high moves rate, eq, de-emphasis to registers at once.
// - in management mode side B eq and side A de-emphasis pins become address straps.
// - other pins stay active until override written; ignored till mode low.
// - registers reset at power-up and when mode select goes low.
// - cable absent high in management mode keeps register contents.
// - every select pin decodes as low, high or floating.
// - eq pair codes FF bypass, HH 4, LL 9.6, FL 11.4 dB.
// - eq pair codes HL 15.5, FH 17, LH 19.1, LF 20.6, HF 26.3.
// - low-rate de-emphasis LL 0, LH -3.5, HL -6, HH -6 enhanced.
// - LF -9, HF -12, FL -9 1200mV, FH -12 1400mV; FF reserved.
// - high rate keeps level and swing but uses 200ps pulse.
// - enhanced pulse adds de-emphasis on the second bit after a change.
// - rate pin low 2.5G, high 5G, floating selects automatic detection.
// - in auto rate, pulse width follows detected rate; level does not.
// - auto rate re-detected after every idle exit; pulse updated.
// - in pin mode all four lanes of a side share one setting.
// - cable absent high means low power; low means normal operation.
module rlcs_top #(
   parameter int LANES = rlcs_pkg::NUM_LANES
) (
   input  wire logic                sys_clk_i,
   input  wire logic                rst_n_i,
   input  wire logic                clk_en_i,
   input  wire logic                mgmt_mode_select_i,
   input  wire logic                cable_absent_in_i,
   input  wire logic [1:0]          rate_pin_i,
   input  wire logic [1:0]          side_a_eq_sel_bit0_i,
   input  wire logic [1:0]          side_a_eq_sel_bit1_i,
   input  wire logic [1:0]          side_b_eq_sel_bit0_i,
   input  wire logic [1:0]          side_b_eq_sel_bit1_i,
   input  wire logic [1:0]          side_a_deemph_sel_bit0_i,
   input  wire logic [1:0]          side_a_deemph_sel_bit1_i,
   input  wire logic [1:0]          side_b_deemph_sel_bit0_i,
   input  wire logic [1:0]          side_b_deemph_sel_bit1_i,
   input  wire logic [1:0]          term_ctrl_side_i,
   input  wire logic [1:0]          detected_high_rate_i,
   input  wire logic [1:0]          idle_exit_i,
   input  wire logic [3:0]          reg_addr_i,
   input  wire logic [15:0]         reg_wdata_i,
   input  wire logic                reg_wr_i,
   input  wire logic                reg_rd_i,
   output logic      [15:0]         reg_rdata_o,
   output logic      [3:0]          bus_addr_straps_o,
   output logic      [2*LANES*4-1:0] lane_eq_o,
   output logic      [2*LANES*3-1:0] lane_de_level_o,
   output logic      [2*LANES*2-1:0] lane_de_width_o,
   output logic      [2*LANES-1:0]   lane_de_enh_o,
   output logic      [2*LANES*2-1:0] lane_swing_o,
   output logic      [2*LANES-1:0]   lane_term_dis_o,
   output logic                     low_power_o,
   output logic                     cfg_error_o,
   output logic                     mgmt_active_o
);
   localparam int NL = 2 * LANES;

   ////////////////////////////////////////////////////////////////////////
   // pin decode per side

   logic [1:0] pin_high_rate;
   logic [1:0] rate_hi_lat;
   logic [3:0] side_eq [2];
   logic [2:0] side_lvl [2];
   logic [1:0] side_pw [2];
   logic [1:0] side_enh;
   logic [1:0] side_sw [2];
   logic [1:0] side_rsvd;

   // auto rate is latched on idle exit so width cannot move mid-burst
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rate_hi_lat <= 2'h0;
      end else if (clk_en_i) begin
         for (int s = 0; s < 2; s++) begin
            if (idle_exit_i[s]) begin
               rate_hi_lat[s] <= detected_high_rate_i[s];
            end
         end
      end
   end

   function automatic logic rate_is_high(input logic [1:0] src,
                                         input logic       lat);
      rate_is_high = (src == rlcs_pkg::RATE_HIGH) ||
                     ((src == rlcs_pkg::RATE_AUTO) && lat);
   endfunction

   always_comb begin
      for (int s = 0; s < 2; s++) begin
         pin_high_rate[s] = rate_is_high(rate_pin_i, rate_hi_lat[s]);
      end
   end

   rlcs_eq_decode u_eq_a (
      .bit1_i (side_a_eq_sel_bit1_i),
      .bit0_i (side_a_eq_sel_bit0_i),
      .eq_o   (side_eq[0])
   );
   rlcs_eq_decode u_eq_b (
      .bit1_i (side_b_eq_sel_bit1_i),
      .bit0_i (side_b_eq_sel_bit0_i),
      .eq_o   (side_eq[1])
   );
   rlcs_de_decode u_de_a (
      .bit1_i      (side_a_deemph_sel_bit1_i),
      .bit0_i      (side_a_deemph_sel_bit0_i),
      .high_rate_i (pin_high_rate[0]),
      .level_o     (side_lvl[0]),
      .width_o     (side_pw[0]),
      .enh_o       (side_enh[0]),
      .swing_o     (side_sw[0]),
      .rsvd_o      (side_rsvd[0])
   );
   rlcs_de_decode u_de_b (
      .bit1_i      (side_b_deemph_sel_bit1_i),
      .bit0_i      (side_b_deemph_sel_bit0_i),
      .high_rate_i (pin_high_rate[1]),
      .level_o     (side_lvl[1]),
      .width_o     (side_pw[1]),
      .enh_o       (side_enh[1]),
      .swing_o     (side_sw[1]),
      .rsvd_o      (side_rsvd[1])
   );

   ////////////////////////////////////////////////////////////////////////
   // mode tracking

   rlcs_pkg::rlcs_mode_t mode;
   rlcs_pkg::rlcs_mode_t next_mode;

   always_comb begin
      next_mode = mode;
      unique case (mode)
         rlcs_pkg::RLCS_ST_PIN:
            if (mgmt_mode_select_i) next_mode = rlcs_pkg::RLCS_ST_MGMT;
         rlcs_pkg::RLCS_ST_MGMT:
            if (!mgmt_mode_select_i) next_mode = rlcs_pkg::RLCS_ST_PIN;
            else if (cable_absent_in_i) next_mode = rlcs_pkg::RLCS_ST_HOLD;
         rlcs_pkg::RLCS_ST_HOLD:
            if (!mgmt_mode_select_i) next_mode = rlcs_pkg::RLCS_ST_PIN;
            else if (!cable_absent_in_i) next_mode = rlcs_pkg::RLCS_ST_MGMT;
         default: next_mode = rlcs_pkg::RLCS_ST_PIN;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         mode <= rlcs_pkg::RLCS_ST_PIN;
      end else if (clk_en_i) begin
         mode <= next_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-lane registers

   logic [3:0]  r_eq   [NL];
   logic [2:0]  r_lvl  [NL];
   logic        r_enh  [NL];
   logic [1:0]  r_sw   [NL];
   logic        r_tdis [NL];
   logic        r_tovr [NL];
   logic [1:0]  r_rate;
   logic        r_povr;
   logic        wr_hit_glb;

   assign wr_hit_glb = reg_wr_i && (reg_addr_i == rlcs_pkg::ADDR_GLOBAL);

   // mode select low clears; cable absent only freezes writes-free state
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || (clk_en_i && !mgmt_mode_select_i)) begin
         for (int l = 0; l < NL; l++) begin
            r_eq[l]   <= rlcs_pkg::REG_EQ_RST;
            r_lvl[l]  <= rlcs_pkg::REG_DE_RST;
            r_enh[l]  <= rlcs_pkg::REG_ENH_RST;
            r_sw[l]   <= rlcs_pkg::REG_SW_RST;
            r_tdis[l] <= rlcs_pkg::REG_TDIS_RST;
            r_tovr[l] <= 1'b0;
         end
         r_rate <= rlcs_pkg::REG_RATE_RST;
         r_povr <= 1'b0;
      end else if (clk_en_i && reg_wr_i) begin
         for (int l = 0; l < NL; l++) begin
            if (reg_addr_i == rlcs_pkg::ADDR_LANE0 + 4'(l)) begin
               r_eq[l]   <= reg_wdata_i[rlcs_pkg::F_EQ_LO +: 4];
               r_lvl[l]  <= reg_wdata_i[rlcs_pkg::F_DE_LO +: 3];
               r_enh[l]  <= reg_wdata_i[rlcs_pkg::F_ENH];
               r_sw[l]   <= reg_wdata_i[rlcs_pkg::F_SW_LO +: 2];
               r_tdis[l] <= reg_wdata_i[rlcs_pkg::F_TDIS];
               r_tovr[l] <= reg_wdata_i[rlcs_pkg::F_TOVR];
            end
         end
         if (wr_hit_glb) begin
            r_rate <= reg_wdata_i[rlcs_pkg::F_RATE_LO +: 2];
            r_povr <= reg_wdata_i[rlcs_pkg::F_POVR];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // source select and outputs

   logic       mgmt;
   logic [1:0] reg_hi;
   logic [1:0] held_valid;

   assign mgmt = mgmt_mode_select_i;
   always_comb begin
      for (int s = 0; s < 2; s++) begin
         reg_hi[s] = rate_is_high(r_rate, rate_hi_lat[s]);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         lane_eq_o       <= '0;
         lane_de_level_o <= '0;
         lane_de_width_o <= '0;
         lane_de_enh_o   <= '0;
         lane_swing_o    <= '0;
         lane_term_dis_o <= '0;
         held_valid      <= 2'h0;
      end else if (clk_en_i) begin
         for (int l = 0; l < NL; l++) begin
            if (mgmt) begin
               lane_eq_o[l*4 +: 4]       <= r_eq[l];
               lane_de_level_o[l*3 +: 3] <= r_lvl[l];
               lane_de_width_o[l*2 +: 2] <= (r_lvl[l] == rlcs_pkg::DE_0DB) ?
                  rlcs_pkg::PW_NONE :
                  (reg_hi[l/LANES] ? rlcs_pkg::PW_200PS
                                   : rlcs_pkg::PW_400PS);
               lane_de_enh_o[l]          <= r_enh[l];
               lane_swing_o[l*2 +: 2]    <= r_sw[l];
            end else begin
               lane_eq_o[l*4 +: 4] <= side_eq[l/LANES];
               if (!side_rsvd[l/LANES]) begin
                  lane_de_level_o[l*3 +: 3] <= side_lvl[l/LANES];
                  lane_de_width_o[l*2 +: 2] <= side_pw[l/LANES];
                  lane_de_enh_o[l]          <= side_enh[l/LANES];
                  lane_swing_o[l*2 +: 2]    <= side_sw[l/LANES];
               end
            end
            // termination pin stays live until override set
            if (mgmt && r_tovr[l]) begin
               lane_term_dis_o[l] <= r_tdis[l];
            end else begin
               lane_term_dis_o[l] <= !term_ctrl_side_i[l/LANES];
            end
         end
         for (int s = 0; s < 2; s++) begin
            held_valid[s] <= mgmt ? 1'b0 : !side_rsvd[s];
         end
      end
   end

   // low power and error flag
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         low_power_o   <= 1'b0;
         cfg_error_o   <= 1'b0;
         mgmt_active_o <= 1'b0;
      end else if (clk_en_i) begin
         low_power_o   <= (mgmt && r_povr) ? 1'b0
                                           : cable_absent_in_i;
         cfg_error_o   <= !mgmt && (side_rsvd != 2'h0);
         mgmt_active_o <= mgmt;
      end
   end

   // strap capture: side B eq and side A de-emphasis pins read as address bits
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         bus_addr_straps_o <= 4'h0;
      end else if (clk_en_i) begin
         bus_addr_straps_o <= mgmt ?
            {side_b_eq_sel_bit1_i == rlcs_pkg::RLCS_LVL_HIGH,
             side_b_eq_sel_bit0_i == rlcs_pkg::RLCS_LVL_HIGH,
             side_a_deemph_sel_bit1_i == rlcs_pkg::RLCS_LVL_HIGH,
             side_a_deemph_sel_bit0_i == rlcs_pkg::RLCS_LVL_HIGH} : 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register read port

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 16'h0;
      end else if (clk_en_i) begin
         reg_rdata_o <= 16'h0;
         if (reg_rd_i) begin
            for (int l = 0; l < NL; l++) begin
               if (reg_addr_i == rlcs_pkg::ADDR_LANE0 + 4'(l)) begin
                  reg_rdata_o <= {4'h0, r_tovr[l], r_tdis[l], r_sw[l],
                                  r_enh[l], r_lvl[l], r_eq[l]};
               end
            end
            if (reg_addr_i == rlcs_pkg::ADDR_GLOBAL) begin
               reg_rdata_o <= {13'h0, r_povr, r_rate};
            end
            if (reg_addr_i == rlcs_pkg::ADDR_STATUS) begin
               reg_rdata_o <= {10'h0, held_valid, rate_hi_lat,
                               cfg_error_o, low_power_o};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   property p_reg_clear;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && !mgmt_mode_select_i) |=> (r_eq[0] == rlcs_pkg::REG_EQ_RST);
   endproperty
   a_reg_clear: assert property (p_reg_clear)
      else $error("registers not cleared in pin mode");

   property p_pin_eq;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && !mgmt_mode_select_i) |=>
         (lane_eq_o[3:0] == $past(side_eq[0]));
   endproperty
   a_pin_eq: assert property (p_pin_eq)
      else $error("pin eq not applied");

   property p_reg_eq;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && mgmt_mode_select_i) |=> (lane_eq_o[3:0] == $past(r_eq[0]));
   endproperty
   a_reg_eq: assert property (p_reg_eq)
      else $error("register eq not applied");

   property p_rsvd_flag;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && !mgmt_mode_select_i && side_rsvd[0]) |=>
         cfg_error_o && $stable(lane_de_level_o[2:0]);
   endproperty
   a_rsvd_flag: assert property (p_rsvd_flag)
      else $error("reserved code not held");

   property p_low_power;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && !mgmt_mode_select_i) |=>
         (low_power_o == $past(cable_absent_in_i));
   endproperty
   a_low_power: assert property (p_low_power)
      else $error("low power does not follow cable absent");

   property p_term_pin;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && !mgmt_mode_select_i) |=>
         (lane_term_dis_o[0] == !$past(term_ctrl_side_i[0]));
   endproperty
   a_term_pin: assert property (p_term_pin)
      else $error("termination pin not applied");

   property p_share;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && !mgmt_mode_select_i) |=> (lane_eq_o[3:0] == lane_eq_o[7:4]);
   endproperty
   a_share: assert property (p_share)
      else $error("side lanes differ in pin mode");

   property p_mgmt_flag;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      clk_en_i |=> (mgmt_active_o == $past(mgmt_mode_select_i));
   endproperty
   a_mgmt_flag: assert property (p_mgmt_flag)
      else $error("mode flag lags");

   // cable absent must not disturb register contents in management mode
   property p_retain;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (clk_en_i && !reg_wr_i && mgmt_mode_select_i &&
         mode == rlcs_pkg::RLCS_ST_HOLD) |=> $stable(r_eq[0]);
   endproperty
   a_retain: assert property (p_retain)
      else $error("registers lost while cable absent");
endmodule

// file: testbench/rlcs_strap_model.sv
// board strap model driving the nine three-level select pins
`timescale 1ns/1ns
module rlcs_strap_model (
   input  wire logic [17:0] req_i,
   output logic      [17:0] pins_o
);
   logic [1:0] lv;
   // a strap is low, high or open; code 3 cannot exist on a board
   always_comb begin
      pins_o = 18'h0;
      for (int p = 0; p < 9; p++) begin
         lv = req_i[p*2+:2];
         pins_o[p*2+:2] = (lv == 2'h3) ? 2'h2 : lv;
      end
   end
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the lane configuration select block
`timescale 1ns/1ns
module tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        mode = 1'b0;
   logic        absent = 1'b0;
   logic [17:0] req = 18'h0;
   logic [17:0] pins;
   logic [1:0]  term = 2'h0;
   logic [1:0]  det = 2'h0;
   logic [1:0]  idle = 2'h0;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        en = 1'b1;
   logic [15:0] rdata;
   logic [3:0]  straps;
   logic [31:0] eq;
   logic [23:0] lvl;
   logic [15:0] wid;
   logic [15:0] sw;
   logic [7:0]  enh;
   logic [7:0]  tdis;
   logic        lp;
   logic        err;
   logic        mact;
   int          mismatches = 0;
   int          tests_run = 0;
   // index is bit1*3+bit0 with low 0, high 1, float 2
   localparam logic [35:0] EQT = {4'h0, 4'h5, 4'h3, 4'h8, 4'h1, 4'h4,
                                  4'h7, 4'h6, 4'h2};
   localparam logic [47:0] DET = {6'h26, 6'h1d, 6'h24, 6'h14, 6'h10,
                                  6'h1c, 6'h08, 6'h00};
   always #5 clk = ~clk;
   rlcs_strap_model straps_m (.req_i(req), .pins_o(pins));
   rlcs_top uut (.sys_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en),
      .mgmt_mode_select_i(mode), .cable_absent_in_i(absent),
      .rate_pin_i(pins[1:0]), .side_a_eq_sel_bit0_i(pins[3:2]),
      .side_a_eq_sel_bit1_i(pins[5:4]), .side_b_eq_sel_bit0_i(pins[7:6]),
      .side_b_eq_sel_bit1_i(pins[9:8]),
      .side_a_deemph_sel_bit0_i(pins[11:10]),
      .side_a_deemph_sel_bit1_i(pins[13:12]),
      .side_b_deemph_sel_bit0_i(pins[15:14]),
      .side_b_deemph_sel_bit1_i(pins[17:16]), .term_ctrl_side_i(term),
      .detected_high_rate_i(det), .idle_exit_i(idle), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .bus_addr_straps_o(straps), .lane_eq_o(eq),
      .lane_de_level_o(lvl), .lane_de_width_o(wid), .lane_de_enh_o(enh),
      .lane_swing_o(sw), .lane_term_dis_o(tdis), .low_power_o(lp),
      .cfg_error_o(err), .mgmt_active_o(mact));
   function automatic logic [17:0] mk(int r, int ea, int eb, int da, int db);
      return {2'(db/3), 2'(db%3), 2'(da/3), 2'(da%3), 2'(eb/3), 2'(eb%3),
              2'(ea/3), 2'(ea%3), 2'(r)};
   endfunction
   // width is derived: none at 0 dB, otherwise set by the rate
   function automatic logic [7:0] de_exp(input int i, input logic hi);
      logic [5:0] e;
      e = DET[i*6+:6];
      return {e[5:3], (e[5:3] == 3'h0) ? 2'h0 : (hi ? 2'h2 : 2'h1), e[2:0]};
   endfunction
   function automatic logic [7:0] seen(input int l);
      return {lvl[l*3+:3], wid[l*2+:2], enh[l], sw[l*2+:2]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic setp(input logic [17:0] r);
      @(posedge clk);
      req <= r;
      cyc(2);
   endtask
   task automatic wrr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      final_report();
   end
   initial begin
      void'($urandom(32'h47c724d2));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         setp(mk(0, i, 8 - i, 0, 0));
         chk(eq, {{4{EQT[(8-i)*4+:4]}}, {4{EQT[i*4+:4]}}});
      end
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < 8; i++) begin
            setp(mk(r, 8, 8, i, 7 - i));
            chk({err, seen(4), seen(0)},
                {1'b0, de_exp(7 - i, r[0]), de_exp(i, r[0])});
         end
      end
      setp(mk(0, 8, 8, 8, 0));
      chk({err, seen(0)}, {1'b1, de_exp(7, 1'b1)});
      @(posedge clk);
      det <= 2'h1;
      setp(mk(2, 8, 8, 1, 1));
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         det <= 2'(1 - k);
         idle <= 2'h3;
         @(posedge clk);
         idle <= 2'h0;
         cyc(2);
         chk({seen(4), seen(0)},
             {de_exp(1, 1'b0), de_exp(1, k == 0)});
      end
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         term <= 2'($urandom);
         absent <= 1'($urandom);
         cyc(2);
         chk({tdis, lp}, {{4{~term[1]}}, {4{~term[0]}}, absent});
      end
      // enable low: pin changes must not reach the outputs
      @(posedge clk);
      en <= 1'b0;
      term <= ~term;
      absent <= ~absent;
      cyc(2);
      chk({tdis, lp}, {{4{term[1]}}, {4{term[0]}}, ~absent});
      @(posedge clk);
      en <= 1'b1;
      mode <= 1'b1;
      absent <= 1'b0;
      term <= 2'h3;
      req <= mk(0, 4, 3, 1, 0);
      cyc(2);
      chk({mact, straps, eq[7:0]}, {1'b1, 4'h9, 8'h0});
      wrr(4'h0, 16'h0021);
      wrr(4'h1, 16'h0c08);
      cyc(2);
      chk({eq[7:0], lvl[2:0], tdis[1:0]}, {8'h81, 3'h2, 2'h2});
      @(posedge clk);
      absent <= 1'b1;
      cyc(2);
      rdc(4'h0, 16'h0021);
      rdc(4'ha, 16'h0000);
      rdc(4'h1, 16'h0c08);
      // global word: high rate and low-power override while cable absent
      wrr(4'h8, 16'h0005);
      cyc(2);
      chk({lp, wid[3:0]}, {1'b0, 4'h2});
      rdc(4'h8, 16'h0005);
      @(posedge clk);
      mode <= 1'b0;
      absent <= 1'b0;
      cyc(2);
      @(posedge clk);
      mode <= 1'b1;
      cyc(2);
      rdc(4'h0, 16'h0000);
      final_report();
   end
endmodule
